// >>> design/nand_bus_cycle.sv
// one strobed bus cycle on the flash pins: write or read of a single byte
`timescale 1ns/10ps
`default_nettype none
module nand_bus_cycle (
  // clock and reset
  input  wire logic                 sys_clk_in,
  input  wire logic                 sys_rst_in,
  // request
  input  wire logic                 start_in,
  input  wire nand_host_pkg::phase_t phase_in,
  input  wire logic [7:0]           wdata_in,
  output logic                      done_out,
  output logic [7:0]                rdata_out,
  // pins, already synchronised on input
  input  wire logic [7:0]           io_sync_in,
  output logic [7:0]                io_out,
  output logic                      io_oe_out,
  output logic                      cmd_sel_out,
  output logic                      addr_sel_out,
  output logic                      write_strobe_n_out,
  output logic                      output_strobe_n_out
);

  // ****************
  // strobe sequencer
  // ****************
  logic [3:0]            cnt_q;
  logic                  low_q;
  logic                  busy_q;
  nand_host_pkg::phase_t ph_q;

  // low half then high half; bytes latch on the rising edge we make
  always_ff @(posedge sys_clk_in) begin
    done_out <= 1'b0;
    if (sys_rst_in) begin
      cnt_q               <= 4'h0;
      low_q               <= 1'b0;
      busy_q              <= 1'b0;
      ph_q                <= nand_host_pkg::PH_CMD;
      io_out              <= 8'h00;
      io_oe_out           <= 1'b0;
      cmd_sel_out         <= 1'b0;
      addr_sel_out        <= 1'b0;
      write_strobe_n_out  <= 1'b1;
      output_strobe_n_out <= 1'b1;
      rdata_out           <= 8'h00;
    end else if (start_in && !busy_q) begin
      busy_q       <= 1'b1;
      low_q        <= 1'b1;
      ph_q         <= phase_in;
      cnt_q        <= 4'(nand_host_pkg::STROBE_LOW_CYC - 1);
      cmd_sel_out  <= (phase_in == nand_host_pkg::PH_CMD);
      addr_sel_out <= (phase_in == nand_host_pkg::PH_ADDR);
      io_out       <= wdata_in;
      io_oe_out    <= (phase_in != nand_host_pkg::PH_RD);
      if (phase_in == nand_host_pkg::PH_RD) begin
        output_strobe_n_out <= 1'b0;
      end else begin
        write_strobe_n_out <= 1'b0;
      end
    end else if (busy_q && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (busy_q && low_q) begin
      // sample read data at the end of the low half, one cycle short of the valid delay plus sync
      if (ph_q == nand_host_pkg::PH_RD) begin
        rdata_out <= io_sync_in;
      end
      low_q               <= 1'b0;
      write_strobe_n_out  <= 1'b1;
      output_strobe_n_out <= 1'b1;
      cnt_q               <= 4'(nand_host_pkg::STROBE_HIGH_CYC - 1);
    end else if (busy_q) begin
      // hold data and selects through the high half for hold time
      busy_q       <= 1'b0;
      done_out     <= 1'b1;
      io_oe_out    <= 1'b0;
      cmd_sel_out  <= 1'b0;
      addr_sel_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> design/nand_flash_host.sv
// host controller driving a nand flash over its parallel pins
`timescale 1ns/10ps
`default_nettype none
module nand_flash_host #(
  parameter int TIMEOUT_CYC = 2000000
) (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  // user request
  input  wire logic        req_valid_in,
  input  wire logic [2:0]  req_op_in,
  input  wire logic        req_half_in,
  input  wire logic [25:0] req_addr_in,
  input  wire logic [9:0]  req_len_in,
  output logic             req_ready_out,
  // user write data, taken one byte per handshake
  input  wire logic [7:0]  wr_data_in,
  output logic             wr_take_out,
  // user read data
  output logic [7:0]       rd_data_out,
  output logic             rd_valid_out,
  // completion
  output logic             op_done_out,
  output logic [7:0]       op_status_out,
  output logic             op_timeout_out,
  // flash pins
  input  wire logic [7:0]  io_in,
  output logic [7:0]       io_out,
  output logic             io_oe_out,
  output logic             chip_select_n_out,
  output logic             command_latch_select_out,
  output logic             address_latch_select_out,
  output logic             write_strobe_n_out,
  output logic             output_strobe_n_out,
  output logic             erase_lock_n_out,
  input  wire logic        busy_flag_n_in,
  output logic             busy_pull_oe_out
);

  // ****************
  // input synchronisers
  // ****************
  logic [7:0] io_m_q;
  logic [7:0] io_s_q;
  logic       rb_m_q;
  logic       rb_s_q;

  // pins are asynchronous to us; first stage feeds only the second
  always_ff @(posedge sys_clk_in) begin
    io_m_q <= io_in;
    io_s_q <= io_m_q;
    rb_m_q <= busy_flag_n_in;
    rb_s_q <= rb_m_q;
  end

  // ****************
  // sequencer
  // ****************
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_CMD1  = 4'b0001,
    ST_ADDR  = 4'b0010,
    ST_DATA  = 4'b0011,
    ST_CMD2  = 4'b0100,
    ST_WAIT  = 4'b0101,
    ST_BUSY  = 4'b0110,
    ST_READ  = 4'b0111,
    ST_STCMD = 4'b1000,
    ST_STRD  = 4'b1001,
    ST_DONE  = 4'b1010
  } state_t;

  state_t                state_q;
  logic [2:0]            op_q;
  logic                  half_q;
  logic [25:0]           addr_q;
  logic [9:0]            len_q;
  logic [9:0]            bytes_q;
  logic [2:0]            acyc_q;
  logic [31:0]           tmo_q;
  logic                  cyc_start_q;
  nand_host_pkg::phase_t cyc_phase_q;
  logic [7:0]            cyc_wdata_q;
  logic                  cyc_done;
  logic [7:0]            cyc_rdata;

  // one strobed byte per request; cycle engine owns pin timing
  nand_bus_cycle u_cycle (
    .sys_clk_in          (sys_clk_in),
    .sys_rst_in          (sys_rst_in),
    .start_in            (cyc_start_q),
    .phase_in            (cyc_phase_q),
    .wdata_in            (cyc_wdata_q),
    .done_out            (cyc_done),
    .rdata_out           (cyc_rdata),
    .io_sync_in          (io_s_q),
    .io_out              (io_out),
    .io_oe_out           (io_oe_out),
    .cmd_sel_out         (command_latch_select_out),
    .addr_sel_out        (address_latch_select_out),
    .write_strobe_n_out  (write_strobe_n_out),
    .output_strobe_n_out (output_strobe_n_out)
  );

  // address byte by cycle index: column, then rows, erase skips column
  function automatic logic [7:0] addr_byte(input logic [25:0] a, input logic [2:0] idx);
    unique case (idx)
      3'h0:    addr_byte = a[7:0];
      3'h1:    addr_byte = a[16:9];
      3'h2:    addr_byte = a[24:17];
      default: addr_byte = {7'h00, a[25]};
    endcase
  endfunction

  // main operation flow
  always_ff @(posedge sys_clk_in) begin
    cyc_start_q  <= 1'b0;
    wr_take_out  <= 1'b0;
    rd_valid_out <= 1'b0;
    op_done_out  <= 1'b0;
    if (sys_rst_in) begin
      state_q        <= ST_IDLE;
      op_q           <= nand_host_pkg::OP_READ;
      half_q         <= 1'b0;
      addr_q         <= 26'h0000000;
      len_q          <= 10'h000;
      bytes_q        <= 10'h000;
      acyc_q         <= 3'h0;
      tmo_q          <= 32'h00000000;
      cyc_phase_q    <= nand_host_pkg::PH_CMD;
      cyc_wdata_q    <= 8'h00;
      req_ready_out  <= 1'b0;
      rd_data_out    <= 8'h00;
      op_status_out  <= 8'h00;
      op_timeout_out <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          req_ready_out <= rb_s_q;
          if (req_valid_in && req_ready_out) begin
            req_ready_out  <= 1'b0;
            op_q           <= req_op_in;
            half_q         <= req_half_in;
            addr_q         <= req_addr_in;
            len_q          <= req_len_in;
            bytes_q        <= 10'h000;
            op_timeout_out <= 1'b0;
            tmo_q          <= 32'h00000000;
            acyc_q         <= (req_op_in == nand_host_pkg::OP_ERASE) ?
                              3'(nand_host_pkg::ADDR_CYCLES - nand_host_pkg::ERASE_ADDR_CYC) :
                              3'h0;
            cyc_phase_q    <= nand_host_pkg::PH_CMD;
            cyc_start_q    <= 1'b1;
            state_q        <= (req_op_in == nand_host_pkg::OP_RESET) ? ST_WAIT : ST_CMD1;
            unique case (req_op_in)
              nand_host_pkg::OP_PROG:   cyc_wdata_q <= nand_host_pkg::CMD_PROG_SETUP;
              nand_host_pkg::OP_ERASE:  cyc_wdata_q <= nand_host_pkg::CMD_ERASE_SETUP;
              nand_host_pkg::OP_STATUS: cyc_wdata_q <= nand_host_pkg::CMD_STATUS;
              nand_host_pkg::OP_RESET:  cyc_wdata_q <= nand_host_pkg::CMD_RESET;
              default: cyc_wdata_q <= req_half_in ? nand_host_pkg::CMD_READ_B
                                                  : nand_host_pkg::CMD_READ_A;
            endcase
            if (req_op_in == nand_host_pkg::OP_STATUS) begin
              state_q <= ST_STCMD;
            end
          end
        end
        ST_CMD1: if (cyc_done) begin
          cyc_phase_q <= nand_host_pkg::PH_ADDR;
          cyc_wdata_q <= addr_byte(addr_q, acyc_q);
          cyc_start_q <= 1'b1;
          state_q     <= ST_ADDR;
        end
        ST_ADDR: if (cyc_done) begin
          if (acyc_q != 3'(nand_host_pkg::ADDR_CYCLES - 1)) begin
            acyc_q      <= acyc_q + 3'h1;
            cyc_wdata_q <= addr_byte(addr_q, acyc_q + 3'h1);
            cyc_start_q <= 1'b1;
          end else if (op_q == nand_host_pkg::OP_ERASE) begin
            cyc_phase_q <= nand_host_pkg::PH_CMD;
            cyc_wdata_q <= nand_host_pkg::CMD_ERASE_GO;
            cyc_start_q <= 1'b1;
            state_q     <= ST_CMD2;
          end else if (op_q == nand_host_pkg::OP_PROG) begin
            state_q <= ST_DATA;
          end else begin
            tmo_q   <= 32'h00000000;
            state_q <= ST_WAIT;
          end
        end
        ST_DATA: if (bytes_q == len_q && (cyc_done || len_q == 10'h000)) begin
          cyc_phase_q <= nand_host_pkg::PH_CMD;
          cyc_wdata_q <= nand_host_pkg::CMD_PROG_GO;
          cyc_start_q <= 1'b1;
          state_q     <= ST_CMD2;
        end else if (!cyc_start_q && (cyc_done || bytes_q == 10'h000 && !wr_take_out)) begin
          cyc_phase_q <= nand_host_pkg::PH_WR;
          cyc_wdata_q <= wr_data_in;
          wr_take_out <= 1'b1;
          cyc_start_q <= 1'b1;
          bytes_q     <= bytes_q + 10'h001;
        end
        ST_CMD2: if (cyc_done) begin
          tmo_q   <= 32'h00000000;
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          // the flag needs a short while to fall after the final strobe
          tmo_q <= tmo_q + 32'h00000001;
          if (tmo_q == 32'(nand_host_pkg::BUSY_WAIT_CYC + 2)) begin
            state_q <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          tmo_q <= tmo_q + 32'h00000001;
          if (rb_s_q) begin
            bytes_q <= 10'h000;
            if (op_q == nand_host_pkg::OP_READ) begin
              cyc_phase_q <= nand_host_pkg::PH_RD;
              cyc_start_q <= 1'b1;
              state_q     <= ST_READ;
            end else if (op_q == nand_host_pkg::OP_RESET) begin
              state_q <= ST_DONE;
            end else begin
              cyc_phase_q <= nand_host_pkg::PH_CMD;
              cyc_wdata_q <= nand_host_pkg::CMD_STATUS;
              cyc_start_q <= 1'b1;
              state_q     <= ST_STCMD;
            end
          end else if (tmo_q == 32'(TIMEOUT_CYC)) begin
            op_timeout_out <= 1'b1;
            state_q        <= ST_DONE;
          end
        end
        ST_READ: if (cyc_done) begin
          rd_data_out  <= cyc_rdata;
          rd_valid_out <= 1'b1;
          bytes_q      <= bytes_q + 10'h001;
          if (bytes_q + 10'h001 == len_q) begin
            state_q <= ST_DONE;
          end else begin
            cyc_start_q <= 1'b1;
          end
        end
        ST_STCMD: if (cyc_done) begin
          cyc_phase_q <= nand_host_pkg::PH_RD;
          cyc_start_q <= 1'b1;
          state_q     <= ST_STRD;
        end
        ST_STRD: if (cyc_done) begin
          op_status_out <= cyc_rdata;
          state_q       <= ST_DONE;
        end
        default: begin
          op_done_out <= 1'b1;
          state_q     <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************
  // static pin controls
  // ****************
  // select stays low; toggling it while busy would be ignored anyway
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      chip_select_n_out <= 1'b1;
      erase_lock_n_out  <= 1'b0;
      busy_pull_oe_out  <= 1'b0;
    end else begin
      chip_select_n_out <= 1'b0;
      erase_lock_n_out  <= 1'b1;
      busy_pull_oe_out  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> design/nand_host_pkg.sv
// constants for the nand flash host controller
//
// Operation
// - eight-bit shared bus carries commands, addresses, write data out and read data in.
// - command latch select high: byte captured on write strobe rising edge.
// - address latch select high: byte captured on write strobe rising edge.
// - busy flag is open drain, host supplies pull-up; this host has no pull-up and holds busy_pull_oe_out low.
// - commands: 00h/01h read, 80h then 10h program, 60h then D0h erase.
// - four address cycles: column then rows; erase sends three row cycles.
package nand_host_pkg;

  // ****************
  // command bytes
  // ****************
  localparam logic [7:0] CMD_READ_A    = 8'h00;
  localparam logic [7:0] CMD_READ_B    = 8'h01;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_GO   = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO  = 8'hD0;
  localparam logic [7:0] CMD_STATUS    = 8'h70;
  localparam logic [7:0] CMD_RESET     = 8'hFF;

  // ****************
  // operation codes on the user port
  // ****************
  localparam logic [2:0] OP_READ   = 3'h0;
  localparam logic [2:0] OP_PROG   = 3'h1;
  localparam logic [2:0] OP_ERASE  = 3'h2;
  localparam logic [2:0] OP_STATUS = 3'h3;
  localparam logic [2:0] OP_RESET  = 3'h4;

  // ****************
  // geometry and timing
  // ****************
  localparam int PAGE_BYTES      = 528;
  localparam int ADDR_CYCLES     = 4;
  localparam int ERASE_ADDR_CYC  = 3;
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int STROBE_LOW_NS   = 25;
  localparam int STROBE_HIGH_NS  = 25;
  localparam int VALID_DELAY_NS  = 20;
  localparam int BUSY_WAIT_NS    = 100;
  localparam int STROBE_LOW_CYC  = (STROBE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int VALID_DELAY_CYC = (VALID_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BUSY_WAIT_CYC   = (BUSY_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // bus phase types
  typedef enum logic [1:0] {
    PH_CMD  = 2'b00,
    PH_ADDR = 2'b01,
    PH_WR   = 2'b10,
    PH_RD   = 2'b11
  } phase_t;

endpackage

// >>> verif/nand_flash_host_bench.sv
// self-checking bench of the nand flash host controller against a device model
`timescale 1ns/10ps
`default_nettype none
module nand_flash_host_bench;
  localparam logic [7:0]  STATUS_OK = 8'hC0;
  localparam logic [16:0] ROW       = 17'h00123;
  logic        sys_clk_in, sys_rst_in, req_valid_in, req_half_in, stuck;
  logic [2:0]  req_op_in;
  logic [25:0] req_addr_in;
  logic [9:0]  req_len_in;
  logic [7:0]  wr_data_in, rd_data_out, op_status_out, io_out, m_io, io_last_q;
  logic        req_ready_out, wr_take_out, rd_valid_out, op_done_out, op_timeout_out, io_oe_out;
  logic        chip_select_n_out, command_latch_select_out, address_latch_select_out;
  logic        write_strobe_n_out, output_strobe_n_out, erase_lock_n_out, busy_pull_oe_out;
  logic        m_oe, m_pull;
  logic [7:0]  wbytes [0:3];
  logic [7:0]  rq [$];
  int          widx, miscompares, checked;
  // a released bus shows the inverse of its last value; busy line has a pull-up
  wire logic [7:0] io_bus = io_oe_out ? io_out : m_oe ? m_io : ~io_last_q;
  wire logic       busy_n = !(m_pull || busy_pull_oe_out);
  nand_flash_host #(.TIMEOUT_CYC(2000)) i_nand_flash_host (
    .sys_clk_in, .sys_rst_in, .req_valid_in, .req_op_in, .req_half_in, .req_addr_in,
    .req_len_in, .req_ready_out, .wr_data_in, .wr_take_out, .rd_data_out, .rd_valid_out,
    .op_done_out, .op_status_out, .op_timeout_out, .io_in(io_bus), .io_out, .io_oe_out,
    .chip_select_n_out, .command_latch_select_out, .address_latch_select_out,
    .write_strobe_n_out, .output_strobe_n_out, .erase_lock_n_out, .busy_flag_n_in(busy_n),
    .busy_pull_oe_out);
  nand_flash_model #(.STATUS_OK(STATUS_OK)) i_nand_flash_model (
    .chip_select_n_in(chip_select_n_out), .cmd_sel_in(command_latch_select_out),
    .addr_sel_in(address_latch_select_out), .write_strobe_n_in(write_strobe_n_out),
    .output_strobe_n_in(output_strobe_n_out), .erase_lock_n_in(erase_lock_n_out),
    .stuck_in(stuck), .io_in(io_bus), .io_out(m_io), .io_oe_out(m_oe), .busy_pull_out(m_pull));
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  // ****************
  // collectors and shared tasks
  // ****************
  always @(posedge sys_clk_in) begin
    if (io_oe_out || m_oe) io_last_q <= io_bus;
    if (rd_valid_out === 1'b1) rq.push_back(rd_data_out);
    if (wr_take_out === 1'b1) widx <= widx + 1;
  end
  always @(negedge sys_clk_in) wr_data_in <= wbytes[widx % 4];
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp, input string what);
    cmp8({7'h00, got}, {7'h00, exp}, what);
  endtask
  // 0 ready, 1 done, 2 timeout; a passing wait also counts as a check
  task automatic wait_hi(input int w, input int lim, input string what);
    checked++;
    repeat (lim) begin
      @(posedge sys_clk_in);
      if ((w == 0 ? req_ready_out : w == 1 ? op_done_out : op_timeout_out) === 1'b1) return;
    end
    miscompares++;
    $display("[FAIL] %0t %s", $time, what);
  endtask
  // two idle cycles first keep the spacing after the previous completion
  task automatic request(input logic [2:0] op, input logic h, input logic [25:0] a,
                         input logic [9:0] n);
    repeat (2) @(negedge sys_clk_in);
    rq.delete();
    req_valid_in = 1'b1;
    req_op_in = op;
    req_half_in = h;
    req_addr_in = a;
    req_len_in = n;
    wait_hi(0, 4000, "request not taken");
    @(negedge sys_clk_in);
    req_valid_in = 1'b0;
  endtask
  task automatic run_op(input logic [2:0] op, input logic [25:0] a);
    request(op, 1'b0, a, 10'd0);
    wait_hi(1, 3000, "no completion");
  endtask
  task automatic read_check(input logic h, input logic [25:0] a, input logic [7:0] exp [$]);
    request(nand_host_pkg::OP_READ, h, a, 10'(exp.size()));
    wait_hi(1, 3000, "read not done");
    repeat (2) @(posedge sys_clk_in);
    cmp8(8'(rq.size()), 8'(exp.size()), "read count");
    foreach (exp[i]) cmp8(rq[i], exp[i], "read byte");
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    wait_hi(0, 20, "not ready after reset");
    cmp1(erase_lock_n_out, 1'b1, "erase lock");
    cmp1(chip_select_n_out, 1'b0, "chip select");
    $display("test reset done");
  endtask
  task automatic t_program;
    wbytes = '{8'h5A, 8'hA5, 8'h3C, 8'hC3};
    widx = 0;
    request(nand_host_pkg::OP_PROG, 1'b0, {ROW, 9'h0FE}, 10'd4);
    for (int i = 0; i < 400 && busy_n !== 1'b0; i++) @(posedge sys_clk_in);
    repeat (5) @(posedge sys_clk_in);
    cmp1(req_ready_out, 1'b0, "ready while busy");
    wait_hi(1, 3000, "program not done");
    cmp8(op_status_out, STATUS_OK, "program status");
    cmp8(8'(widx), 8'h04, "bytes taken");
    $display("test program done");
  endtask
  task automatic t_read;
    read_check(1'b0, {ROW, 9'h0FE}, {8'h5A, 8'hA5, 8'h3C, 8'hC3});
    read_check(1'b1, {ROW, 9'h100}, {8'h3C, 8'hC3});
    $display("test read done");
  endtask
  task automatic t_erase;
    run_op(nand_host_pkg::OP_ERASE, {ROW, 9'h000});
    cmp8(op_status_out, STATUS_OK, "erase status");
    read_check(1'b0, {ROW, 9'h0FE}, {8'hFF, 8'hFF});
    $display("test erase done");
  endtask
  task automatic t_status_reset;
    run_op(nand_host_pkg::OP_RESET, 26'h0000000);
    run_op(nand_host_pkg::OP_STATUS, 26'h0000000);
    cmp8(op_status_out, STATUS_OK, "status byte");
    $display("test status and reset done");
  endtask
  task automatic t_timeout;
    @(negedge sys_clk_in);
    stuck = 1'b1;
    request(nand_host_pkg::OP_ERASE, 1'b0, {ROW, 9'h000}, 10'd0);
    wait_hi(2, 2800, "no timeout");
    stuck = 1'b0;
    wait_hi(0, 2000, "not ready after stall");
    run_op(nand_host_pkg::OP_STATUS, 26'h0000000);
    cmp1(op_timeout_out, 1'b0, "timeout not cleared");
    $display("test timeout done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    {sys_rst_in, req_valid_in, req_half_in, stuck} = 4'b1000;
    {req_op_in, req_addr_in, req_len_in, wr_data_in, io_last_q} = '0;
    {widx, miscompares, checked} = '0;
    repeat (20) @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    t_reset;
    t_program;
    t_read;
    t_erase;
    t_status_reset;
    t_timeout;
    tally_and_finish;
  end
  // the whole run needs well under 9000 cycles
  initial begin
    #(12000 * 5);
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// >>> verif/nand_flash_host_checker.sv
// assertion checker on the pins of the nand flash host controller
`timescale 1ns/10ps
`default_nettype none
module nand_flash_host_checker #(
  parameter int TIMEOUT_CYC = 2000000
) (
  // clock, reset and user side
  input wire logic       sys_clk_in,
  input wire logic       sys_rst_in,
  input wire logic       req_ready_out,
  input wire logic       op_done_out,
  input wire logic       op_timeout_out,
  // flash pins
  input wire logic [7:0] io_out,
  input wire logic       io_oe_out,
  input wire logic       command_latch_select_out,
  input wire logic       address_latch_select_out,
  input wire logic       write_strobe_n_out,
  input wire logic       output_strobe_n_out,
  input wire logic       erase_lock_n_out,
  input wire logic       busy_flag_n_in,
  input wire logic       busy_pull_oe_out
);
  int busy_cnt_q;
  // cycles the busy flag has been low, to judge a timeout
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || busy_flag_n_in) busy_cnt_q <= 0;
    else busy_cnt_q <= busy_cnt_q + 1;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ****************
  // pin protocol
  // ****************
  property p_sel_excl; !(command_latch_select_out && address_latch_select_out); endproperty
  a_sel_excl: assert property (p_sel_excl) else $error("both latch selects high");
  property p_sel_hold;
    $rose(write_strobe_n_out) |-> $stable(command_latch_select_out) && $stable(address_latch_select_out);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select moved at strobe");
  property p_data_hold; $rose(write_strobe_n_out) |-> io_oe_out && $stable(io_out); endproperty
  a_data_hold: assert property (p_data_hold) else $error("bus not held at strobe");
  property p_we_width; $fell(write_strobe_n_out) |-> (!write_strobe_n_out)[*5] ##1 write_strobe_n_out; endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width");
  property p_rd_cycle;
    $fell(output_strobe_n_out) |-> (!output_strobe_n_out)[*5] ##1 output_strobe_n_out[*5];
  endproperty
  a_rd_cycle: assert property (p_rd_cycle) else $error("read cycle shape");
  property p_no_clash; !output_strobe_n_out |-> !io_oe_out && write_strobe_n_out; endproperty
  a_no_clash: assert property (p_no_clash) else $error("host drives during read");
  property p_lock_off; !$past(sys_rst_in) |-> erase_lock_n_out; endproperty
  a_lock_off: assert property (p_lock_off) else $error("erase lock held");
  property p_ready_busy; (!busy_flag_n_in)[*4] |-> !req_ready_out; endproperty
  a_ready_busy: assert property (p_ready_busy) else $error("ready while busy");
  property p_busy_cmd;
    $rose(write_strobe_n_out) && command_latch_select_out && !busy_flag_n_in
      |-> io_out == 8'h70 || io_out == 8'hFF;
  endproperty
  a_busy_cmd: assert property (p_busy_cmd) else $error("command while busy");
  property p_done_pulse; op_done_out |=> !op_done_out; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
  property p_pull; !busy_pull_oe_out; endproperty
  a_pull: assert property (p_pull) else $error("host drives busy line");
  property p_timeout; $rose(op_timeout_out) |-> busy_cnt_q > TIMEOUT_CYC / 2; endproperty
  a_timeout: assert property (p_timeout) else $error("early timeout");
endmodule
bind nand_flash_host nand_flash_host_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_checker (
  .sys_clk_in, .sys_rst_in, .req_ready_out, .op_done_out, .op_timeout_out, .io_out,
  .io_oe_out, .command_latch_select_out, .address_latch_select_out, .write_strobe_n_out,
  .output_strobe_n_out, .erase_lock_n_out, .busy_flag_n_in, .busy_pull_oe_out);
`default_nettype wire

// >>> verif/nand_flash_model.sv
// behavioural nand flash device answering the host controller pins
`timescale 1ns/10ps
`default_nettype none
module nand_flash_model #(
  parameter logic [7:0] STATUS_OK = 8'hC0,
  parameter int         READ_NS   = 300,
  parameter int         PROG_NS   = 1000,
  parameter int         ERASE_NS  = 2000
) (
  // control pins
  input  wire logic       chip_select_n_in,
  input  wire logic       cmd_sel_in,
  input  wire logic       addr_sel_in,
  input  wire logic       write_strobe_n_in,
  input  wire logic       output_strobe_n_in,
  input  wire logic       erase_lock_n_in,
  input  wire logic       stuck_in,
  // data bus and busy line
  input  wire logic [7:0] io_in,
  output logic [7:0]      io_out,
  output logic            io_oe_out,
  output logic            busy_pull_out
);
  logic [7:0] mem [int];
  logic [7:0] pend [int];
  logic [7:0] cmd_q, op;
  logic [7:0] abyte [0:3];
  logic       half, stat_mode, drv;
  int         acnt, col, row, dur;
  event       go;
  initial begin
    busy_pull_out = 1'b0;
    drv = 1'b0;
    half = 1'b0;
    io_out = 8'h00;
  end
  // ****************
  // byte intake, taken on the rising write strobe only
  // ****************
  always @(posedge write_strobe_n_in) begin
    if (!chip_select_n_in && cmd_sel_in) begin
      cmd_q = io_in;
      acnt = 0;
      stat_mode = (io_in == 8'h70);
      if (io_in == 8'h00 || io_in == 8'h01) half = io_in[0];
      if (io_in == 8'h80) pend.delete();
      if (io_in == 8'h10 || io_in == 8'hD0 || io_in == 8'hFF) ->go;
    end else if (!chip_select_n_in && addr_sel_in) begin
      if (acnt < 4) abyte[acnt] = io_in;
      acnt++;
      if (cmd_q == 8'h60 && acnt == 3) row = {abyte[2][0], abyte[1], abyte[0]};
      if (cmd_q != 8'h60 && acnt == 4) begin
        row = {abyte[3][0], abyte[2], abyte[1]};
        col = abyte[0] + (half ? 256 : 0);
        half = 1'b0;
        if (cmd_q != 8'h80) ->go;
      end
    end else if (!chip_select_n_in) begin
      pend[col] = io_in;
      col++;
    end
  end
  // internal work behind the busy line; chip select is not looked at meanwhile
  always begin
    @(go);
    op = cmd_q;
    dur = (op == 8'hD0) ? ERASE_NS : (op == 8'h10) ? PROG_NS : READ_NS;
    if (stuck_in) dur = 15000;
    #50 busy_pull_out = 1'b1;
    #(dur) busy_pull_out = 1'b0;
    if (erase_lock_n_in && op == 8'h10) foreach (pend[c]) mem[row * 528 + c] = pend[c];
    if (erase_lock_n_in && op == 8'hD0)
      for (int a = row / 32 * 32 * 528; a < (row / 32 + 1) * 32 * 528; a++)
        if (mem.exists(a)) mem.delete(a);
  end
  // data 10ns after the strobe falls, inside the valid delay
  always @(negedge output_strobe_n_in) begin
    #10 io_out = stat_mode ? (busy_pull_out ? (STATUS_OK & 8'hBF) : STATUS_OK)
                 : mem.exists(row * 528 + col) ? mem[row * 528 + col] : 8'hFF;
    drv = 1'b1;
    if (!stat_mode) col++;
  end
  always @(posedge output_strobe_n_in) #10 drv = 1'b0;
  assign io_oe_out = drv && !chip_select_n_in;
endmodule
`default_nettype wire
